// file: inc/rcc_pkg.sv
// Purpose: Constants and types shared by the reset and clock control block.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per word.
// Notes:   Overview of operation follows.
//
// Overview of operation
// (R1) Three trim modes: automatic, factory, user.
// (R2) Automatic trim needs hibernation present, enabled, counting.
// (R3) User trim is 7 bits, 0x40 nominal.
// (R4) Trim above nominal slows, below speeds oscillator.
// (R5) Trim result reads 1 success, 0 failure.
// (R6) PWM clock is system clock divided 1..64.
// (R7) Selected PWM divider reads back.
// (R8) Software reset returns whole device to defaults; here the cause and rail flags keep their values.
// (R9) Software reset keeps causes, sets software flag.
// (R10) Each source does full POR or system reset.
// (R11) Unset sources keep type; one write configures all.
// (R12) Reset types of all sources read back.
// (R13) Sticky cause flags until software or power-on clear.
// (R14) Software clears any subset; later causes re-set.
// (R15) Sleep gating keeps only sleep-marked peripheral clocks.
// (R16) Clocked peripherals wake the sleeping processor.
// (R17) Software reads SRAM size in bytes.
// (R18) USB PLL down stops PHY, registers stay.
// (R19) Software powers USB PLL before connecting.
// (R20) Separate rail brown-out flags, cleared by mask.
// (R21) Brown-out flags survive resets, software clear only; here rst, the power-on reset, also clears them.
// (R22) Per-rail brown-out action: none, interrupt, NMI, reset.
// (R23) Flag clearing is write-one-to-clear.
package rcc_pkg;
   // Register byte offsets
   localparam logic [5:0] OFF_TRIM       = 6'h00;
   localparam logic [5:0] OFF_PWM        = 6'h04;
   localparam logic [5:0] OFF_SWRST      = 6'h08;
   localparam logic [5:0] OFF_BEHAV      = 6'h0c;
   localparam logic [5:0] OFF_CAUSE      = 6'h10;
   localparam logic [5:0] OFF_SLEEP_CTL  = 6'h14;
   localparam logic [5:0] OFF_SLEEP_MASK = 6'h18;
   localparam logic [5:0] OFF_SRAM       = 6'h1c;
   localparam logic [5:0] OFF_USBPLL     = 6'h20;
   localparam logic [5:0] OFF_VCFG       = 6'h24;
   localparam logic [5:0] OFF_VSTAT      = 6'h28;
   // Trim register fields
   localparam int TRIM_W          = 7;
   localparam int TRIM_MODE_LSB   = 8;
   localparam int TRIM_RESULT_BIT = 16;
   localparam int TRIM_BUSY_BIT   = 17;
   localparam logic [6:0] TRIM_NOMINAL = 7'h40;
   typedef enum logic [1:0] {
      TRIM_MODE_NONE        = 2'b00,
      TRIM_MODE_AUTOMATIC   = 2'b01,
      TRIM_MODE_FACTORY     = 2'b10,
      TRIM_MODE_USER_VALUE  = 2'b11
   } trim_mode_t;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_MEASURE = 2'b01,
      ST_ADJUST  = 2'b10
   } trim_state_t;
   // Automatic trim measurement
   localparam int SYS_CLK_HZ       = 25_000_000;
   localparam int REF_HZ           = 32_768;
   localparam int OSC_HZ           = 16_000_000;
   localparam int OSC_PRESCALE     = 32;
   localparam int TRIM_REF_PERIODS = 64;
   localparam int TRIM_TARGET      = (OSC_HZ / OSC_PRESCALE) * TRIM_REF_PERIODS / REF_HZ;
   localparam int TRIM_TOL         = 8;
   localparam int TRIM_MAX_STEPS   = 64;
   localparam int TRIM_CNT_W       = 12;
   // PWM divider select, ratio is two to the power of the code
   localparam int PWM_SEL_W = 3;
   localparam logic [2:0] PWM_SEL_MAX   = 3'h6;
   localparam logic [2:0] PWM_SEL_RESET = 3'h0;
   // Reset sources, behaviour and causes
   localparam int SRC_WDOG0 = 0;
   localparam int SRC_WDOG1 = 1;
   localparam int SRC_BOR   = 2;
   localparam int SRC_EXT   = 3;
   localparam logic [3:0] BEHAV_RESET = 4'h0;
   localparam int CAUSE_W            = 6;
   localparam int CAUSE_EXTERNAL_PIN = 0;
   localparam int CAUSE_POWER_ON     = 1;
   localparam int CAUSE_BROWNOUT     = 2;
   localparam int CAUSE_WATCHDOG     = 3;
   localparam int CAUSE_SOFTWARE     = 4;
   localparam int CAUSE_REGULATOR    = 5;
   localparam logic [5:0] CAUSE_RESET = 6'h02;
   localparam int RESET_HOLD_CYCLES  = 16;
   // Brown-out rails and actions
   localparam int RAIL_MAIN   = 0;
   localparam int RAIL_ANALOG = 1;
   localparam int RAIL_CORE   = 2;
   typedef enum logic [1:0] {
      BOR_NONE = 2'b00,
      BOR_INT  = 2'b01,
      BOR_NMI  = 2'b10,
      BOR_RST  = 2'b11
   } bor_action_t;
   localparam logic [5:0] VCFG_RESET = 6'h00;
endpackage

// file: core/reset_and_clock_control.sv
// Purpose: System reset, oscillator trim, PWM clock, sleep gating and flags.
// Assumes: All inputs synchronous to sys_clk; rst is the power-on reset.
// Notes:   Avalon-MM slave with one wait state on every access.
`timescale 1ns/10ps
module reset_and_clock_control #(
   parameter int          NUM_PERIPH   = 8,
   parameter logic [31:0] SRAM_BYTES   = 32'h0000_8000,
   parameter bit          HAS_HIB      = 1'b1,
   parameter logic [6:0]  FACTORY_TRIM = 7'h40
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic [5:0]            address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [3:0]            byteenable,
   input  wire logic [31:0]           writedata,
   output logic      [31:0]           readdata,
   output logic                       waitrequest,
   input  wire logic                  hibEnabled,
   input  wire logic                  rtcRunning,
   input  wire logic                  ref32kTick,
   input  wire logic                  oscTick,
   output logic      [6:0]            oscTrim,
   output logic                       pwmClkEn,
   input  wire logic                  wdog0Rst,
   input  wire logic                  wdog1Rst,
   input  wire logic                  externalResetPin_n,
   input  wire logic                  ldoReset,
   input  wire logic [2:0]            borEvent,
   output logic                       sysResetOut,
   output logic                       fullPorReqOut,
   output logic                       borIntReq,
   output logic                       borNmiReq,
   input  wire logic                  cpuSleep,
   input  wire logic [NUM_PERIPH-1:0] periphWake,
   output logic      [NUM_PERIPH-1:0] periphClkEn,
   output logic                       cpuWake,
   output logic                       usbPllPowerUp,
   output logic                       usbPhyEnable
);
   import rcc_pkg::*;

   logic                  ack_reg;
   logic [31:0]           rd_reg;
   logic                  wrEn;
   logic                  wrFull;
   logic [6:0]            trim_reg;
   logic                  result_reg;
   logic                  busy_reg;
   trim_state_t           state_reg;
   logic [TRIM_CNT_W-1:0] oscCnt_reg;
   logic [6:0]            refCnt_reg;
   logic [6:0]            steps_reg;
   logic [2:0]            pwmSel_reg;
   logic [5:0]            pwmCnt_reg;
   logic [5:0]            pwmMask;
   logic [3:0]            behav_reg;
   logic [CAUSE_W-1:0]    cause_reg;
   logic [CAUSE_W-1:0]    causeSet;
   logic [CAUSE_W-1:0]    causeClr;
   logic [CAUSE_W-1:0]    keepCause;
   logic                  gating_reg;
   logic [NUM_PERIPH-1:0] sleepMask_reg;
   logic                  usbPll_reg;
   logic [5:0]            vcfg_reg;
   logic [2:0]            vstat_reg;
   logic [2:0]            vstatClr;
   logic [4:0]            hold_reg;
   logic                  swReq;
   logic [3:0]            srcReq;
   logic                  anyReq;
   logic                  porSel;
   logic                  cfgClr;
   logic [2:0]            borRst;
   logic [2:0]            borInt;
   logic [2:0]            borNmi;
   logic                  autoAllowed;
   logic                  trimStart;
   trim_mode_t            trimMode;
   logic [3:0]            behavNext;

   // One wait state: the request is taken at the second edge after it rises
   assign waitrequest = (read | write) & ~ack_reg;
   assign wrEn        = write & ack_reg;
   assign wrFull      = wrEn & (byteenable == 4'hf);
   assign readdata    = rd_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read | write) & ~ack_reg;
      end
   end

   // Read data is captured during the wait state so it is stable at the answer edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_reg <= 32'h0;
      end else if (read & ~ack_reg) begin
         case (address)
            OFF_TRIM:       rd_reg <= {14'h0, busy_reg, result_reg, 9'h0, trim_reg}; // R5
            OFF_PWM:        rd_reg <= {29'h0, pwmSel_reg}; // R7
            OFF_BEHAV: begin
               for (int i = 0; i < 4; i++) begin
                  rd_reg[2*i]   <= behav_reg[i]; // R12
                  rd_reg[2*i+1] <= ~behav_reg[i];
               end
               rd_reg[31:8] <= 24'h0;
            end
            OFF_CAUSE:      rd_reg <= {26'h0, cause_reg};
            OFF_SLEEP_CTL:  rd_reg <= {31'h0, gating_reg};
            OFF_SLEEP_MASK: rd_reg <= 32'(sleepMask_reg);
            OFF_SRAM:       rd_reg <= SRAM_BYTES; // R17
            OFF_USBPLL:     rd_reg <= {31'h0, usbPll_reg};
            OFF_VCFG:       rd_reg <= {26'h0, vcfg_reg};
            OFF_VSTAT:      rd_reg <= {29'h0, vstat_reg};
            default:        rd_reg <= 32'h0;
         endcase
      end
   end

   // Reset requests from every source
   assign swReq  = wrFull & (address == OFF_SWRST) & writedata[0];
   assign srcReq = {~externalResetPin_n, |borRst, wdog1Rst, wdog0Rst};
   assign anyReq = swReq | (|srcReq) | ldoReset;
   // Full POR wins if any requesting source is configured for it; software is always system
   assign porSel = (|(srcReq & behav_reg)) | ldoReset; // R10
   // Device registers return to default on any reset except the flags
   assign cfgClr = rst | anyReq; // R8

   // Reset output stretcher; a retrigger restarts the hold
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hold_reg      <= 5'h0;
         sysResetOut   <= 1'b0;
         fullPorReqOut <= 1'b0;
      end else if (anyReq) begin
         hold_reg      <= 5'(RESET_HOLD_CYCLES);
         sysResetOut   <= ~porSel; // R10
         fullPorReqOut <= porSel;
      end else if (hold_reg > 5'h1) begin
         hold_reg <= hold_reg - 5'h1;
      end else begin
         hold_reg      <= 5'h0;
         sysResetOut   <= 1'b0;
         fullPorReqOut <= 1'b0;
      end
   end

   // Reset behaviour: a field pair of 01 picks POR, 10 picks system, else unchanged
   always_comb begin
      behavNext = behav_reg;
      for (int i = 0; i < 4; i++) begin
         if (writedata[2*i] & ~writedata[2*i+1]) begin
            behavNext[i] = 1'b1; // R11
         end else if (writedata[2*i+1] & ~writedata[2*i]) begin
            behavNext[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (cfgClr) begin
         behav_reg <= BEHAV_RESET;
      end else if (wrFull && address == OFF_BEHAV) begin
         behav_reg <= behavNext; // R11
      end
   end

   // Cause flags: sticky, set wins over a same-cycle clear
   assign causeSet = {ldoReset, swReq, wdog0Rst | wdog1Rst, |borRst, 1'b0,
                      ~externalResetPin_n};
   assign causeClr = (wrEn && address == OFF_CAUSE) ? writedata[5:0] : 6'h0; // R23
   assign keepCause = cause_reg & ~causeClr;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cause_reg <= CAUSE_RESET; // R13
      end else begin
         cause_reg <= keepCause | causeSet; // R9 R13 R14
      end
   end

   // Brown-out actions per rail
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         borRst[i] = borEvent[i] & (vcfg_reg[2*i +: 2] == BOR_RST); // R22
         borInt[i] = borEvent[i] & (vcfg_reg[2*i +: 2] == BOR_INT);
         borNmi[i] = borEvent[i] & (vcfg_reg[2*i +: 2] == BOR_NMI);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (cfgClr) begin
         vcfg_reg <= VCFG_RESET;
      end else if (wrFull && address == OFF_VCFG) begin
         vcfg_reg <= writedata[5:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         borIntReq <= 1'b0;
         borNmiReq <= 1'b0;
      end else begin
         borIntReq <= |borInt; // R22
         borNmiReq <= |borNmi;
      end
   end

   // Rail flags ignore system resets; only a write of one or the power-on reset clears a bit
   assign vstatClr = (wrEn && address == OFF_VSTAT) ? writedata[2:0] : 3'h0;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         vstat_reg <= 3'h0;
      end else begin
         vstat_reg <= (vstat_reg & ~vstatClr) | borEvent; // R20 R21 R23
      end
   end

   // PWM divider select; unsupported codes are ignored
   always_ff @(posedge sys_clk) begin
      if (cfgClr) begin
         pwmSel_reg <= PWM_SEL_RESET;
      end else if (wrFull && address == OFF_PWM && writedata[2:0] <= PWM_SEL_MAX) begin
         pwmSel_reg <= writedata[2:0]; // R7
      end
   end

   // Enable pulse once every two-to-the-code cycles
   assign pwmMask = 6'((7'h1 << pwmSel_reg) - 7'h1);
   always_ff @(posedge sys_clk) begin
      if (cfgClr) begin
         pwmCnt_reg <= 6'h0;
         pwmClkEn   <= 1'b0;
      end else begin
         pwmCnt_reg <= pwmCnt_reg + 6'h1;
         pwmClkEn   <= (pwmCnt_reg & pwmMask) == pwmMask; // R6
      end
   end

   // Sleep control and peripheral clock gating
   always_ff @(posedge sys_clk) begin
      if (cfgClr) begin
         gating_reg    <= 1'b0;
         sleepMask_reg <= '0;
         usbPll_reg    <= 1'b0;
      end else if (wrFull) begin
         if (address == OFF_SLEEP_CTL) begin
            gating_reg <= writedata[0];
         end
         if (address == OFF_SLEEP_MASK) begin
            sleepMask_reg <= writedata[NUM_PERIPH-1:0];
         end
         if (address == OFF_USBPLL) begin
            usbPll_reg <= writedata[0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         periphClkEn   <= '1;
         cpuWake       <= 1'b0;
         usbPllPowerUp <= 1'b0;
         usbPhyEnable  <= 1'b0;
      end else begin
         periphClkEn   <= (cpuSleep & gating_reg) ? sleepMask_reg : '1; // R15
         cpuWake       <= cpuSleep & (|(periphWake & periphClkEn)); // R16
         usbPllPowerUp <= usbPll_reg;
         usbPhyEnable  <= usbPll_reg; // R18
      end
   end

   // Oscillator trim: commands while busy are ignored
   assign trimMode    = trim_mode_t'(writedata[TRIM_MODE_LSB +: 2]);
   assign trimStart   = wrFull & (address == OFF_TRIM) & ~busy_reg;
   assign autoAllowed = HAS_HIB & hibEnabled & rtcRunning; // R2

   always_ff @(posedge sys_clk) begin
      if (cfgClr) begin
         state_reg  <= ST_IDLE;
         trim_reg   <= FACTORY_TRIM;
         result_reg <= 1'b0;
         busy_reg   <= 1'b0;
         oscCnt_reg <= '0;
         refCnt_reg <= 7'h0;
         steps_reg  <= 7'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (trimStart) begin
                  case (trimMode)
                     TRIM_MODE_AUTOMATIC: begin
                        if (autoAllowed) begin
                           state_reg  <= ST_MEASURE; // R1
                           busy_reg   <= 1'b1;
                           oscCnt_reg <= '0;
                           refCnt_reg <= 7'h0;
                           steps_reg  <= 7'h0;
                        end else begin
                           result_reg <= 1'b0; // R2
                        end
                     end
                     TRIM_MODE_FACTORY: begin
                        trim_reg   <= FACTORY_TRIM; // R1
                        result_reg <= 1'b1;
                     end
                     TRIM_MODE_USER_VALUE: begin
                        trim_reg   <= writedata[TRIM_W-1:0]; // R3
                        result_reg <= 1'b1;
                     end
                     default: result_reg <= result_reg;
                  endcase
               end
            end
            ST_MEASURE: begin
               if (!autoAllowed) begin
                  state_reg  <= ST_IDLE; // R2
                  busy_reg   <= 1'b0;
                  result_reg <= 1'b0;
               end else begin
                  if (oscTick) begin
                     oscCnt_reg <= oscCnt_reg + 1'b1;
                  end
                  if (ref32kTick) begin
                     refCnt_reg <= refCnt_reg + 7'h1;
                     if (refCnt_reg == 7'(TRIM_REF_PERIODS - 1)) begin
                        state_reg <= ST_ADJUST;
                     end
                  end
               end
            end
            ST_ADJUST: begin
               oscCnt_reg <= '0;
               refCnt_reg <= 7'h0;
               if (oscCnt_reg + TRIM_CNT_W'(TRIM_TOL) >= TRIM_CNT_W'(TRIM_TARGET) &&
                   oscCnt_reg <= TRIM_CNT_W'(TRIM_TARGET + TRIM_TOL)) begin
                  state_reg  <= ST_IDLE; // R5
                  busy_reg   <= 1'b0;
                  result_reg <= 1'b1;
               end else if (steps_reg == 7'(TRIM_MAX_STEPS - 1)) begin
                  state_reg  <= ST_IDLE;
                  busy_reg   <= 1'b0;
                  result_reg <= 1'b0;
               end else begin
                  state_reg <= ST_MEASURE;
                  steps_reg <= steps_reg + 7'h1;
                  // Too many ticks means too fast, so a larger code slows it
                  if (oscCnt_reg > TRIM_CNT_W'(TRIM_TARGET) && trim_reg != 7'h7f) begin
                     trim_reg <= trim_reg + 7'h1; // R4
                  end else if (oscCnt_reg < TRIM_CNT_W'(TRIM_TARGET) && trim_reg != 7'h0) begin
                     trim_reg <= trim_reg - 7'h1; // R4
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end
   assign oscTrim = trim_reg;

   // Checks next to the logic they guard
   a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (rst)
      (read || write) && waitrequest |=> !waitrequest)
      else $error("access not answered after one wait state");
   // Any flag set before a cycle without a clear write must still be set after it
   a_cause_sticky: assert property (@(posedge sys_clk) disable iff (rst) // R13
      !(write && address == OFF_CAUSE) |=> (cause_reg & $past(cause_reg)) == $past(cause_reg))
      else $error("cause flag lost without a clear");
   a_sw_reset_flag: assert property (@(posedge sys_clk) disable iff (rst) // R9
      swReq |=> cause_reg[CAUSE_SOFTWARE] && sysResetOut && !fullPorReqOut)
      else $error("software reset did not flag or reset");
   a_reset_hold: assert property (@(posedge sys_clk) disable iff (rst) // R8
      $rose(sysResetOut) |-> sysResetOut [*8])
      else $error("system reset pulse too short");
   a_wdog_por_route: assert property (@(posedge sys_clk) disable iff (rst) // R10
      wdog0Rst && behav_reg[SRC_WDOG0] |=> fullPorReqOut && !sysResetOut)
      else $error("watchdog did not request a full POR");
   a_rail_flag_set: assert property (@(posedge sys_clk) disable iff (rst) // R20
      (|borEvent) |=> ((vstat_reg & $past(borEvent)) == $past(borEvent)))
      else $error("brown-out event not recorded");
   a_user_trim_load: assert property (@(posedge sys_clk) disable iff (rst) // R3
      trimStart && trimMode == TRIM_MODE_USER_VALUE && !anyReq
      |=> oscTrim == $past(writedata[6:0]) && result_reg)
      else $error("user trim value not loaded");
   a_auto_blocked: assert property (@(posedge sys_clk) disable iff (rst) // R2
      trimStart && trimMode == TRIM_MODE_AUTOMATIC && !autoAllowed && !anyReq
      |=> !busy_reg && !result_reg)
      else $error("automatic trim started without reference");
   a_pwm_half_rate: assert property (@(posedge sys_clk) disable iff (rst) // R6
      pwmSel_reg == 3'h1 && $stable(pwmSel_reg) && pwmClkEn && !anyReq |=> !pwmClkEn)
      else $error("divide-by-two enable pulsed twice in a row");
   a_sleep_gating: assert property (@(posedge sys_clk) disable iff (rst) // R15
      cpuSleep && gating_reg && !anyReq |=> periphClkEn == $past(sleepMask_reg))
      else $error("sleep gating does not follow sleep mask");
endmodule

// file: verification/reset_and_clock_control_test.sv
// Purpose: Self-checking bench for the reset and clock control block.
// Assumes: Avalon-MM accesses end at the edge where waitrequest is low.
// Notes:   Every wait is bounded; a spent bound counts as a mismatch.
`timescale 1ns/10ps
module reset_and_clock_control_test;
   import rcc_pkg::*;
   logic        sys_clk, rst, read, write, hibEnabled, rtcRunning, ref32kTick, oscTick;
   logic        wdog0Rst, wdog1Rst, externalResetPin_n, ldoReset, cpuSleep;
   logic        waitrequest, pwmClkEn, sysResetOut, fullPorReqOut, borIntReq, borNmiReq;
   logic        cpuWake, usbPllPowerUp, usbPhyEnable;
   logic [5:0]  address;
   logic [3:0]  byteenable;
   logic [31:0] writedata, readdata, q;
   logic [6:0]  oscTrim;
   logic [2:0]  borEvent;
   logic [7:0]  periphWake, periphClkEn;
   int          miscompares, compares, i, k;

   reset_and_clock_control u_dut (.*);

   // Free-running 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic print_verdict();
      $display("Compares %0d, miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One access; the request holds until waitrequest is seen low
   task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] d);
      int w;
      @(posedge sys_clk);
      address <= a; write <= wr; read <= ~wr; writedata <= d;
      w = 0;
      do begin @(negedge sys_clk); w++; end while (waitrequest !== 1'b0 && w < 50);
      if (w >= 50) begin miscompares++; print_verdict(); end
      // This edge sees waitrequest low: the write lands and read data is taken
      @(posedge sys_clk);
      q = readdata;
      read <= 1'b0; write <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      check(q & m, e);
   endtask

   // Poll the trim status until the operation is no longer busy
   task automatic trimDone();
      k = 0;
      do begin bus(OFF_TRIM, 1'b0, 32'h0); k++; end while (q[TRIM_BUSY_BIT] !== 1'b0 && k < 300);
      if (k >= 300) begin miscompares++; print_verdict(); end
   endtask

   // One-cycle pulse on {ldo, pin, rails, wdog1, wdog0}; the pin idles high
   // Returns at the falling edge after the design has registered its answer
   task automatic kick(input logic [6:0] m);
      @(posedge sys_clk);
      {ldoReset, externalResetPin_n, borEvent, wdog1Rst, wdog0Rst} <= m ^ 7'h20;
      @(posedge sys_clk);
      {ldoReset, externalResetPin_n, borEvent, wdog1Rst, wdog0Rst} <= 7'h20;
      @(negedge sys_clk);
   endtask

   initial begin
      {read, write, ref32kTick, oscTick, wdog0Rst, wdog1Rst, ldoReset, cpuSleep} = '0;
      {address, writedata, borEvent, periphWake} = '0;
      {rst, hibEnabled, rtcRunning, externalResetPin_n} = 4'hf;
      byteenable = 4'hf;
      miscompares = 0;
      compares = 0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      // Power-on defaults
      rd(OFF_CAUSE, 32'h3f, 32'h02);
      rd(OFF_TRIM, 32'h7f, 32'h40);
      rd(OFF_BEHAV, 32'hff, 32'haa);
      rd(OFF_SRAM, 32'hffffffff, 32'h8000);
      rd(6'h3c, 32'hffffffff, 32'h0);
      // Every PWM ratio, then an illegal code that must be ignored
      for (i = 0; i < 7; i++) begin
         bus(OFF_PWM, 1'b1, i);
         rd(OFF_PWM, 32'h7, i);
         k = 0;
         repeat (128) begin @(negedge sys_clk); k += pwmClkEn; end
         check(k, 128 >> i);
      end
      bus(OFF_PWM, 1'b1, 32'h7);
      rd(OFF_PWM, 32'h7, 32'h6);
      // User trim, factory restore, automatic without hibernation
      bus(OFF_TRIM, 1'b1, 32'h355);
      trimDone();
      check(oscTrim, 32'h55);
      check(q[TRIM_RESULT_BIT], 1);
      bus(OFF_TRIM, 1'b1, 32'h200);
      trimDone();
      check(oscTrim, 32'h40);
      hibEnabled <= 1'b0;
      bus(OFF_TRIM, 1'b1, 32'h100);
      trimDone();
      check(q[TRIM_RESULT_BIT], 0);
      hibEnabled <= 1'b1;
      // Automatic trim: reference every 15.25 clocks gives exactly the target count
      bus(OFF_TRIM, 1'b1, 32'h100);
      oscTick <= 1'b1;
      for (i = 0; i < 64; i++) begin
         repeat (14 + (i % 4 == 3)) @(posedge sys_clk);
         ref32kTick <= 1'b1;
         @(posedge sys_clk) ref32kTick <= 1'b0;
      end
      oscTick <= 1'b0;
      trimDone();
      check(q[TRIM_RESULT_BIT], 1);
      check(oscTrim, 32'h40);
      // Reset behaviour: first watchdog full POR, brown-out system
      bus(OFF_BEHAV, 1'b1, 32'h21);
      rd(OFF_BEHAV, 32'hff, 32'ha9);
      kick(7'h01);
      check({sysResetOut, fullPorReqOut}, 32'h1);
      repeat (24) @(posedge sys_clk);
      rd(OFF_CAUSE, 32'h08, 32'h08);
      rd(OFF_BEHAV, 32'hff, 32'haa);
      // Software reset keeps causes and restores defaults
      bus(OFF_PWM, 1'b1, 32'h3);
      bus(OFF_SWRST, 1'b1, 32'h1);
      @(negedge sys_clk);
      check({sysResetOut, fullPorReqOut}, 32'h2);
      repeat (24) @(posedge sys_clk);
      rd(OFF_CAUSE, 32'h18, 32'h18);
      rd(OFF_PWM, 32'h7, 32'h0);
      bus(OFF_CAUSE, 1'b1, 32'h08);
      rd(OFF_CAUSE, 32'h18, 32'h10);
      kick(7'h02);
      check({sysResetOut, fullPorReqOut}, 32'h2);
      repeat (24) @(posedge sys_clk);
      rd(OFF_CAUSE, 32'h18, 32'h18);
      // Pin reset is a system reset by default; the regulator always asks a full POR
      kick(7'h20);
      check({sysResetOut, fullPorReqOut}, 32'h2);
      repeat (24) @(posedge sys_clk);
      kick(7'h40);
      check({sysResetOut, fullPorReqOut}, 32'h1);
      repeat (24) @(posedge sys_clk);
      rd(OFF_CAUSE, 32'h21, 32'h21);
      // Rail events: main interrupt, analog NMI, core reset
      bus(OFF_VCFG, 1'b1, 32'h39);
      kick(7'h1c);
      check({borIntReq, borNmiReq, sysResetOut}, 32'h7);
      repeat (24) @(posedge sys_clk);
      rd(OFF_VSTAT, 32'h7, 32'h7);
      rd(OFF_CAUSE, 32'h04, 32'h04);
      bus(OFF_SWRST, 1'b1, 32'h1);
      repeat (24) @(posedge sys_clk);
      rd(OFF_VSTAT, 32'h7, 32'h7);
      bus(OFF_VSTAT, 1'b1, 32'h1);
      rd(OFF_VSTAT, 32'h7, 32'h6);
      // Sleep gating keeps only marked clocks; a clocked peripheral wakes
      bus(OFF_SLEEP_MASK, 1'b1, 32'h1);
      bus(OFF_SLEEP_CTL, 1'b1, 32'h1);
      cpuSleep <= 1'b1;
      periphWake <= 8'h02;
      repeat (4) @(posedge sys_clk);
      check(periphClkEn, 32'h01);
      check(cpuWake, 0);
      periphWake <= 8'h01;
      repeat (4) @(posedge sys_clk);
      check(cpuWake, 1);
      periphWake <= 8'h00;
      bus(OFF_SLEEP_CTL, 1'b1, 32'h0);
      repeat (4) @(posedge sys_clk);
      check(periphClkEn, 32'hff);
      cpuSleep <= 1'b0;
      // USB PLL power reaches the physical layer enable
      bus(OFF_USBPLL, 1'b1, 32'h1);
      repeat (3) @(posedge sys_clk);
      check({usbPllPowerUp, usbPhyEnable}, 32'h3);
      rd(OFF_USBPLL, 32'h1, 32'h1);
      print_verdict();
   end
endmodule
